// [core/smme_entry.sv]
// Operation
// - Entry clears control bits 0,1,2,3,16,31
// - Entry clears debug control except bits 11-15
// - Flags 0000002H, pointer 00008000H after save
// - Code selector 3000H, base 00030000H
// - Data/extra/stack selectors, bases zero, 16-bit
// - All segment limits set to FFFFFH
// - Real-like addressing, no 64K limit check
// - Pushes keep only low 16 pointer bits
// - Implicit stack keeps 64K limit
// - Boundary interrupt starts save, not when shutdown
// - Handler fetch always starts at 38000H
// - Coinciding causes give a single entry
// - Region fixed 38000H-3FFFFH; relocation bit zero
// - Chip-select bit 10 compares management qualifier
// - Qualifier equals management mode and no hold
// - Mask bit set ignores management qualifier
// - Revision bit 16 reports I/O restart
// - Resume redoes I/O when slot is 0FFH
// - Entry initialises I/O restart slot to 00H
// - Active output low from entry until resume
// - Resume restarts halt when slot bit 0 set
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module smme_entry
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic mgmt_interrupt_n,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output smme_pkg::smme_out_t status_out
);
   import smme_pkg::*;

   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] seg_base(input logic [15:0] sel);
      seg_base = {12'h000, sel, 4'h0};
   endfunction

   smme_state_t state_r, state_nxt;
   logic [4:0] ctrl_r;
   logic [31:0] main_ctrl_r, dbg_ctrl_r, flags_r, ip_r, cs_base_r, limit_r;
   logic [15:0] cs_sel_r, dseg_sel_r;
   logic [31:0] dseg_base_r;
   logic dseg_big_r;
   logic [7:0] iorst_r, haltrst_r;
   logic [31:0] csla_r, cslm_r, csaddr_r;
   logic [2:0] save_cnt_r;
   logic int_prev_r, pending_r;
   logic redo_io_r, redo_halt_r, active_n_r, qual_r, cs_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rdata_r;

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   wire addr_phase = hsel && hready && htrans[1];
   wire do_wr = wr_pend_r;
   wire [7:0] wa = wr_addr_r;
   wire [7:0] ra = haddr[7:0];

   // Falling edge latched; one level of buffering while busy
   wire int_fall = int_prev_r && !mgmt_interrupt_n;
   wire in_run = (state_r == SM_RUN);
   wire in_resume = (state_r == SM_RESUME);
   wire take_entry = in_run && pending_r && ctrl_r[CTRL_BOUNDARY]
                     && !ctrl_r[CTRL_SHUTDOWN];
   wire save_done = (state_r == SM_SAVE) && (save_cnt_r == SAVE_LAST);
   wire resume_go = (state_r == SM_HANDLER) && ctrl_r[CTRL_RESUME];
   wire mode_on = !in_run;
   wire qual_nxt = mode_on && !ctrl_r[CTRL_HOLD];
   wire [31:0] cmp_addr = {csaddr_r[31:11], qual_nxt, csaddr_r[9:0]};
   wire [31:0] eff_mask = cslm_r;
   // Mask bit set drops the qualifier from the compare
   wire cs_hit = ((cmp_addr ^ csla_r) & ~eff_mask) == 32'h0000_0000;
   wire [31:0] rev_word = {14'h0000, 1'b0, 1'b1, REV_BASE};

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         SM_RUN: if (take_entry) state_nxt = SM_SAVE;
         SM_SAVE: if (save_done) state_nxt = SM_HANDLER;
         SM_HANDLER: if (resume_go) state_nxt = SM_RESUME;
         SM_RESUME: state_nxt = SM_RUN;
         default: state_nxt = SM_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r <= SM_RUN;
         save_cnt_r <= 3'd0;
         int_prev_r <= 1'b1;
         pending_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         save_cnt_r <= (state_r == SM_SAVE) ? save_cnt_r + 3'd1 : 3'd0;
         int_prev_r <= mgmt_interrupt_n;
         // A new edge beats the consume in the same cycle
         if (int_fall)
            pending_r <= 1'b1;
         else if (take_entry)
            pending_r <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_r <= addr_phase && hwrite;
         wr_addr_r <= ra;
         if (addr_phase && !hwrite)
         begin
            if (ra == OFF_CTRL) rdata_r <= {27'h0, ctrl_r};
            else if (ra == OFF_STATUS) rdata_r <= {24'h0, state_r, 1'b0, qual_r, pending_r, !active_n_r};
            else if (ra == OFF_MAIN_CTRL) rdata_r <= main_ctrl_r;
            else if (ra == OFF_DBG_CTRL) rdata_r <= dbg_ctrl_r;
            else if (ra == OFF_FLAGS) rdata_r <= flags_r;
            else if (ra == OFF_IP) rdata_r <= ip_r;
            else if (ra == OFF_CS) rdata_r <= {cs_sel_r, 15'h0, dseg_big_r};
            else if (ra == OFF_DSEG) rdata_r <= dseg_base_r | {16'h0, dseg_sel_r};
            else if (ra == OFF_LIMIT) rdata_r <= limit_r;
            else if (ra == OFF_IORST) rdata_r <= {24'h0, iorst_r};
            else if (ra == OFF_HALTRST) rdata_r <= {24'h0, haltrst_r};
            else if (ra == OFF_REVID) rdata_r <= rev_word;
            else if (ra == OFF_CSLA) rdata_r <= csla_r;
            else if (ra == OFF_CSLM) rdata_r <= cslm_r;
            else if (ra == OFF_CSADDR) rdata_r <= csaddr_r;
            else rdata_r <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Architectural state; entry overrides software writes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_r <= 5'h00;
         main_ctrl_r <= 32'h0000_0000;
         dbg_ctrl_r <= 32'h0000_0000;
         flags_r <= 32'h0000_0002;
         ip_r <= 32'h0000_0000;
         cs_sel_r <= 16'h0000;
         cs_base_r <= 32'h0000_0000;
         dseg_sel_r <= 16'h0000;
         dseg_base_r <= 32'h0000_0000;
         dseg_big_r <= 1'b0;
         limit_r <= 32'h0000_FFFF;
         iorst_r <= 8'h00;
         haltrst_r <= 8'h00;
         csla_r <= 32'h0000_0000;
         cslm_r <= 32'hFFFF_FFFF;
         csaddr_r <= 32'h0000_0000;
      end
      else
      begin
         if (do_wr && wa == OFF_CTRL) ctrl_r <= hwdata[4:0];
         else if (resume_go) ctrl_r[CTRL_RESUME] <= 1'b0;
         if (do_wr && wa == OFF_CSLA) csla_r <= hwdata;
         if (do_wr && wa == OFF_CSLM) cslm_r <= hwdata;
         if (do_wr && wa == OFF_CSADDR) csaddr_r <= hwdata;
         if (take_entry)
         begin
            main_ctrl_r <= main_ctrl_r & ~MAIN_CLEAR_MASK;
            dbg_ctrl_r <= dbg_ctrl_r & DBG_KEEP_MASK;
            haltrst_r <= {7'h00, main_ctrl_r[16]};
            iorst_r <= IORST_SKIP;
         end
         else
         begin
            if (do_wr && wa == OFF_MAIN_CTRL) main_ctrl_r <= hwdata;
            if (do_wr && wa == OFF_DBG_CTRL) dbg_ctrl_r <= hwdata;
            // Only the handler may arm the restart slots
            if (do_wr && wa == OFF_IORST && state_r == SM_HANDLER) iorst_r <= hwdata[7:0];
            if (do_wr && wa == OFF_HALTRST && state_r == SM_HANDLER) haltrst_r <= hwdata[7:0];
         end
         if (save_done)
         begin
            flags_r <= FLAGS_INIT;
            ip_r <= IP_INIT;
            cs_sel_r <= CS_SEL_INIT;
            cs_base_r <= CS_BASE_INIT;
            dseg_sel_r <= 16'h0000;
            dseg_base_r <= seg_base(16'h0000);
            dseg_big_r <= 1'b0;
            limit_r <= LIMIT_INIT;
         end
         else
         begin
            if (do_wr && wa == OFF_FLAGS) flags_r <= hwdata;
            // Pushes in this mode carry only 16 pointer bits
            if (do_wr && wa == OFF_IP) ip_r <= mode_on ? {16'h0, hwdata[15:0]} : hwdata;
            if (do_wr && wa == OFF_DSEG)
            begin
               dseg_sel_r <= hwdata[15:0];
               dseg_base_r <= seg_base(hwdata[15:0]);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         active_n_r <= 1'b1;
         qual_r <= 1'b0;
         cs_r <= 1'b0;
         redo_io_r <= 1'b0;
         redo_halt_r <= 1'b0;
      end
      else
      begin
         // Held low through the resume state so no high pulse precedes the exit
         active_n_r <= !(take_entry || (mode_on && !in_resume));
         qual_r <= qual_nxt;
         cs_r <= cs_hit;
         if (resume_go)
         begin
            redo_io_r <= (iorst_r == IORST_REDO);
            redo_halt_r <= haltrst_r[0];
         end
      end
   end

   assign hrdata = rdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign status_out = '{mgmt_active_n: active_n_r, mgmt_address_qualifier: qual_r,
                         chip_select: cs_r, restart_io: redo_io_r,
                         restart_halt: redo_halt_r};

   ////////////////////////////////////////////////////////////////////
   // Reference compare, formed apart from the datapath
   wire cs_ref = (((csaddr_r ^ csla_r) & ~cslm_r & 32'hFFFF_FBFF) == 32'h0000_0000)
                 && (cslm_r[CS_MGMT_BIT] || (csla_r[CS_MGMT_BIT] == qual_nxt));

   sequence s_entry;
      take_entry ##1 !active_n_r;
   endsequence

   property p_active_on_entry;
      @(posedge hclk) disable iff (!hresetn) take_entry |-> ##1 !active_n_r;
   endproperty
   a_active_on_entry: assert property (p_active_on_entry) else $error("active not low");

   property p_no_shutdown_entry;
      @(posedge hclk) disable iff (!hresetn)
         (in_run && ctrl_r[CTRL_SHUTDOWN]) |=> (state_r == SM_RUN);
   endproperty
   a_no_shutdown_entry: assert property (p_no_shutdown_entry) else $error("entry in shutdown");

   property p_main_clear;
      @(posedge hclk) disable iff (!hresetn)
         take_entry |=> ((main_ctrl_r & MAIN_CLEAR_MASK) == 32'h0000_0000);
   endproperty
   a_main_clear: assert property (p_main_clear) else $error("control bits kept");

   property p_dbg_keep;
      @(posedge hclk) disable iff (!hresetn)
         take_entry |=> (dbg_ctrl_r == ($past(dbg_ctrl_r) & DBG_KEEP_MASK));
   endproperty
   a_dbg_keep: assert property (p_dbg_keep) else $error("debug bits wrong");

   property p_env_load;
      @(posedge hclk) disable iff (!hresetn)
         s_entry ##SAVE_CYCLES 1'b1 |-> (ip_r == IP_INIT && flags_r == FLAGS_INIT
            && cs_sel_r == CS_SEL_INIT && limit_r == LIMIT_INIT && !dseg_big_r);
   endproperty
   a_env_load: assert property (p_env_load) else $error("environment not loaded");

   property p_handler_start;
      @(posedge hclk) disable iff (!hresetn)
         save_done |=> (cs_base_r + ip_r == HANDLER_ADDR && seg_base(cs_sel_r) == cs_base_r);
   endproperty
   a_handler_start: assert property (p_handler_start) else $error("bad handler start");

   property p_iorst_init;
      @(posedge hclk) disable iff (!hresetn) take_entry |=> (iorst_r == IORST_SKIP);
   endproperty
   a_iorst_init: assert property (p_iorst_init) else $error("io slot not cleared");

   property p_qual;
      @(posedge hclk) disable iff (!hresetn)
         qual_r == ($past(mode_on) && !$past(ctrl_r[CTRL_HOLD]));
   endproperty
   a_qual: assert property (p_qual) else $error("qualifier wrong");

   property p_redo_io;
      @(posedge hclk) disable iff (!hresetn)
         resume_go |=> (redo_io_r == ($past(iorst_r) == IORST_REDO));
   endproperty
   a_redo_io: assert property (p_redo_io) else $error("io restart wrong");

   property p_active_release;
      @(posedge hclk) disable iff (!hresetn) resume_go |=> !active_n_r ##1 active_n_r;
   endproperty
   a_active_release: assert property (p_active_release) else $error("active not released");

   property p_rev_bits;
      @(posedge hclk) disable iff (!hresetn)
         (addr_phase && !hwrite && ra == OFF_REVID)
            |=> (rdata_r[REV_IORST_BIT] && !rdata_r[REV_RELOC_BIT]);
   endproperty
   a_rev_bits: assert property (p_rev_bits) else $error("revision bits wrong");

   property p_active_level;
      @(posedge hclk) disable iff (!hresetn) !in_run |-> !active_n_r;
   endproperty
   a_active_level: assert property (p_active_level) else $error("active high in mode");

   property p_boundary_wait;
      @(posedge hclk) disable iff (!hresetn)
         (in_run && !ctrl_r[CTRL_BOUNDARY]) |=> (state_r == SM_RUN);
   endproperty
   a_boundary_wait: assert property (p_boundary_wait) else $error("entry off boundary");

   property p_no_nesting;
      @(posedge hclk) disable iff (!hresetn)
         (state_r == SM_HANDLER && !resume_go) |=> (state_r == SM_HANDLER);
   endproperty
   a_no_nesting: assert property (p_no_nesting) else $error("nested entry");

   property p_data_seg;
      @(posedge hclk) disable iff (!hresetn)
         save_done |=> (dseg_sel_r == 16'h0000 && dseg_base_r == 32'h0000_0000
            && cs_base_r == CS_BASE_INIT);
   endproperty
   a_data_seg: assert property (p_data_seg) else $error("segment state wrong");

   property p_seg_real;
      @(posedge hclk) disable iff (!hresetn)
         (do_wr && wa == OFF_DSEG && !save_done)
            |=> (dseg_base_r == {12'h000, $past(hwdata[15:0]), 4'h0});
   endproperty
   a_seg_real: assert property (p_seg_real) else $error("segment base wrong");

   property p_ip_low16;
      @(posedge hclk) disable iff (!hresetn)
         (do_wr && wa == OFF_IP && mode_on && !save_done) |=> (ip_r[31:16] == 16'h0000);
   endproperty
   a_ip_low16: assert property (p_ip_low16) else $error("pointer high bits kept");

   property p_chip_select;
      @(posedge hclk) disable iff (!hresetn) hresetn |=> (cs_r == $past(cs_ref));
   endproperty
   a_chip_select: assert property (p_chip_select) else $error("chip select wrong");

   property p_halt_capture;
      @(posedge hclk) disable iff (!hresetn)
         take_entry |=> (haltrst_r[0] == $past(main_ctrl_r[16]));
   endproperty
   a_halt_capture: assert property (p_halt_capture) else $error("halt slot wrong");

   property p_halt_restart;
      @(posedge hclk) disable iff (!hresetn)
         resume_go |=> (redo_halt_r == $past(haltrst_r[0]));
   endproperty
   a_halt_restart: assert property (p_halt_restart) else $error("halt restart wrong");
endmodule

// [core/smme_pkg.sv]
package smme_pkg;
   // Register offsets (byte addresses, own choice)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_MAIN_CTRL = 8'h08;
   localparam logic [7:0] OFF_DBG_CTRL = 8'h0C;
   localparam logic [7:0] OFF_FLAGS = 8'h10;
   localparam logic [7:0] OFF_IP = 8'h14;
   localparam logic [7:0] OFF_CS = 8'h18;
   localparam logic [7:0] OFF_DSEG = 8'h1C;
   localparam logic [7:0] OFF_LIMIT = 8'h20;
   localparam logic [7:0] OFF_IORST = 8'h24;
   localparam logic [7:0] OFF_HALTRST = 8'h28;
   localparam logic [7:0] OFF_REVID = 8'h2C;
   localparam logic [7:0] OFF_CSLA = 8'h30;
   localparam logic [7:0] OFF_CSLM = 8'h34;
   localparam logic [7:0] OFF_CSADDR = 8'h38;
   // Control register bits
   localparam int CTRL_BOUNDARY = 0;
   localparam int CTRL_SHUTDOWN = 1;
   localparam int CTRL_HOLD = 2;
   localparam int CTRL_RESUME = 3;
   localparam int CTRL_IOBOUND = 4;
   // Environment values
   localparam logic [31:0] MAIN_CLEAR_MASK = 32'h8001_000F;
   localparam logic [31:0] DBG_KEEP_MASK = 32'h0000_F800;
   localparam logic [31:0] FLAGS_INIT = 32'h0000_0002;
   localparam logic [31:0] IP_INIT = 32'h0000_8000;
   localparam logic [15:0] CS_SEL_INIT = 16'h3000;
   localparam logic [31:0] CS_BASE_INIT = 32'h0003_0000;
   localparam logic [31:0] LIMIT_INIT = 32'h000F_FFFF;
   localparam logic [31:0] HANDLER_ADDR = 32'h0003_8000;
   localparam logic [31:0] MEM_LO = 32'h0003_8000;
   localparam logic [31:0] MEM_HI = 32'h0003_FFFF;
   localparam logic [7:0] IORST_REDO = 8'hFF;
   localparam logic [7:0] IORST_SKIP = 8'h00;
   localparam int REV_IORST_BIT = 16;
   localparam int REV_RELOC_BIT = 17;
   localparam logic [15:0] REV_BASE = 16'h0001; // Arbitrary value
   localparam int CS_MGMT_BIT = 10;
   localparam int SAVE_CYCLES = 4;
   localparam logic [2:0] SAVE_LAST = 3'(SAVE_CYCLES - 1);

   typedef enum logic [3:0] {
      SM_RUN = 4'b0001,
      SM_SAVE = 4'b0010,
      SM_HANDLER = 4'b0100,
      SM_RESUME = 4'b1000
   } smme_state_t;

   typedef struct packed {
      logic mgmt_active_n;
      logic mgmt_address_qualifier;
      logic chip_select;
      logic restart_io;
      logic restart_halt;
   } smme_out_t;
endpackage

// [verif/smme_sys_model.sv]
`timescale 1ns/1ps
module smme_sys_model
(
   input wire logic hclk,
   input wire smme_pkg::smme_out_t status_out,
   output logic mgmt_interrupt_n,
   output logic mem_enable
);
   import smme_pkg::*;
   // Save area and handler memory only reachable through the decode in mode
   assign mem_enable = status_out.chip_select & ~status_out.mgmt_active_n;
   initial mgmt_interrupt_n = 1'b1;
   // Held low two cycles so an inactive sample precedes the active one
   task automatic raise_irq();
      @(posedge hclk);
      mgmt_interrupt_n <= 1'b0;
      repeat (2) @(posedge hclk);
      mgmt_interrupt_n <= 1'b1;
   endtask
endmodule

// [verif/test_system_management_mode_entry.sv]
`timescale 1ns/1ps
module test_system_management_mode_entry;
   import smme_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, mgmt_interrupt_n, mem_enable;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   smme_out_t status_out;
   int n_mismatch = 0;
   int check_count = 0;
   assign hready = hreadyout;
   smme_entry dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .mgmt_interrupt_n(mgmt_interrupt_n), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .status_out(status_out));
   smme_sys_model model (.hclk(hclk), .status_out(status_out),
      .mgmt_interrupt_n(mgmt_interrupt_n), .mem_enable(mem_enable));
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Address phase held until ready, then data phase held until ready
   task automatic bus(input int wr, input logic [7:0] off, input logic [31:0] wd);
      @(posedge hclk);
      htrans <= 2'b10;
      hwrite <= wr[0];
      haddr <= {24'h00_0000, off};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic wait_act(input logic v);
      for (int i = 0; i < 50 && status_out.mgmt_active_n !== v; i++) @(posedge hclk);
      chk({31'h0, status_out.mgmt_active_n}, {31'h0, v});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      bus(0, OFF_REVID, 32'h0);
      chk({30'h0, rd[17:16]}, 32'h0000_0001);
      bus(0, 8'h40, 32'h0);
      chk(rd, 32'h0000_0000);
      chk({30'h0, hresp, hreadyout}, 32'h0000_0001);
      bus(1, OFF_MAIN_CTRL, 32'hFFFF_FFFF);
      bus(1, OFF_DBG_CTRL, 32'hFFFF_FFFF);
   endtask
   // Shutdown blocks entry; the edge stays pending until it clears
   task automatic t_shutdown();
      bus(1, OFF_CTRL, 32'h0000_0003);
      model.raise_irq();
      repeat (20) @(posedge hclk);
      chk({31'h0, status_out.mgmt_active_n}, 32'h0000_0001);
      bus(1, OFF_CTRL, 32'h0000_0001);
      wait_act(1'b0);
      repeat (SAVE_CYCLES + 2) @(posedge hclk);
   endtask
   task automatic t_env();
      bus(0, OFF_MAIN_CTRL, 32'h0);
      chk(rd, 32'hFFFF_FFFF & ~MAIN_CLEAR_MASK);
      bus(0, OFF_DBG_CTRL, 32'h0);
      chk(rd, DBG_KEEP_MASK);
      bus(0, OFF_FLAGS, 32'h0);
      chk(rd, FLAGS_INIT);
      bus(0, OFF_IP, 32'h0);
      chk(rd, IP_INIT);
      bus(0, OFF_CS, 32'h0);
      chk(rd, {CS_SEL_INIT, 16'h0000});
      bus(0, OFF_DSEG, 32'h0);
      chk(rd, 32'h0000_0000);
      bus(0, OFF_LIMIT, 32'h0);
      chk(rd, LIMIT_INIT);
      bus(0, OFF_IORST, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, IORST_SKIP});
      bus(1, OFF_IP, 32'hFFFF_1234);
      bus(0, OFF_IP, 32'h0);
      chk(rd, 32'h0000_1234);
      bus(1, OFF_DSEG, 32'h0000_1234);
      bus(0, OFF_DSEG, 32'h0);
      chk(rd, 32'h0001_2340 | 32'h0000_1234);
   endtask
   // Bit 10 of the compare follows the qualifier unless masked
   task automatic t_csel();
      bus(1, OFF_CSLA, 32'h0003_8400);
      bus(1, OFF_CSLM, 32'h0000_0000);
      bus(1, OFF_CSADDR, MEM_LO);
      repeat (3) @(posedge hclk);
      chk({30'h0, status_out.mgmt_address_qualifier, status_out.chip_select}, 32'h3);
      chk({31'h0, mem_enable}, 32'h0000_0001);
      bus(1, OFF_CTRL, 32'h0000_0005);
      repeat (3) @(posedge hclk);
      chk({30'h0, status_out.mgmt_address_qualifier, status_out.chip_select}, 32'h0);
      bus(1, OFF_CSLM, 32'h0000_0400);
      repeat (3) @(posedge hclk);
      chk({31'h0, status_out.chip_select}, 32'h0000_0001);
      bus(1, OFF_CTRL, 32'h0000_0001);
   endtask
   // A second edge in the handler gives exactly one later entry
   task automatic t_resume();
      model.raise_irq();
      bus(1, OFF_IORST, {24'h0, IORST_REDO});
      bus(1, OFF_HALTRST, 32'h0000_0001);
      bus(1, OFF_CTRL, 32'h0000_0009);
      wait_act(1'b1);
      chk({30'h0, status_out.restart_io, status_out.restart_halt}, 32'h3);
      wait_act(1'b0);
      repeat (SAVE_CYCLES + 2) @(posedge hclk);
      bus(0, OFF_IORST, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, IORST_SKIP});
      bus(1, OFF_HALTRST, 32'h0000_0000);
      bus(1, OFF_CTRL, 32'h0000_0009);
      wait_act(1'b1);
      chk({30'h0, status_out.restart_io, status_out.restart_halt}, 32'h0);
      repeat (20) @(posedge hclk);
      chk({31'h0, status_out.mgmt_active_n}, 32'h0000_0001);
      chk({31'h0, mem_enable}, 32'h0000_0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      chk({31'h0, status_out.mgmt_active_n}, 32'h0000_0001);
      t_reset();
      t_shutdown();
      t_env();
      t_csel();
      t_resume();
      end_of_test();
   end
   // Whole run needs well under 2000 cycles
   initial
   begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
endmodule
